/* File: common/cmou_consts.vh */
`ifndef CMOU_CONSTS_VH
`define CMOU_CONSTS_VH

// APB byte offsets, one aligned word each
`define CMOU_OFS_ONE_CTRL    8'h00
`define CMOU_OFS_ONE_LOW     8'h04
`define CMOU_OFS_ONE_HIGH    8'h08
`define CMOU_OFS_TWO_CTRL    8'h0C
`define CMOU_OFS_TWO_LOW     8'h10
`define CMOU_OFS_TWO_HIGH    8'h14
`define CMOU_OFS_T3_CTRL     8'h18
`define CMOU_OFS_IRQ_STATUS  8'h1C
`define CMOU_OFS_IRQ_MASK    8'h20

// Unit control field positions
`define CMOU_FSEL_MSB        3
`define CMOU_FSEL_LSB        0
`define CMOU_DUTY_FRAC_MSB   5
`define CMOU_DUTY_FRAC_LSB   4
`define CMOU_ENH_CFG_MSB     7
`define CMOU_ENH_CFG_LSB     6

// Timer three control: time-base select bits
`define CMOU_TBS_HIGH_BIT    6
`define CMOU_TBS_LOW_BIT     3

// Interrupt status and mask bit positions
`define CMOU_IRQ_UNIT_ONE    0
`define CMOU_IRQ_UNIT_TWO    1

// Function-select codes
`define CMOU_FSEL_OFF        4'h0
`define CMOU_FSEL_TOGGLE     4'h2
`define CMOU_FSEL_SET_HIGH   4'h8
`define CMOU_FSEL_SET_LOW    4'h9
`define CMOU_FSEL_SW_IRQ     4'hA
`define CMOU_FSEL_SPECIAL    4'hB

// Reset values
`define CMOU_RST_BYTE        8'h00
`define CMOU_RST_MASK        2'h0

// Implemented bits of unit two control; bits 7:6 are held zero
`define CMOU_TWO_CTRL_MASK   8'h3F

// Timing: pin action, flag and trigger follow a match edge in this many cycles
`define CMOU_MATCH_LATENCY   1

`endif

/* File: verilog/cmou_pwm.v */
`timescale 1ns/100ps
`include "cmou_consts.vh"

// Pulse-width generator for one unit, double-buffered duty
module cmou_pwm
#(
   parameter DUTY_W = 10
)
(
   // Clock and reset
   input  wire              core_clk,
   input  wire              reset,
   // Control
   input  wire              pwm_enable,
   input  wire [DUTY_W-1:0] duty_req,
   // Timer two time base
   input  wire [7:0]        timer_two_count,
   input  wire [7:0]        timer_two_period,
   input  wire [1:0]        timer_two_phase,
   // Outputs
   output reg  [DUTY_W-1:0] duty_latched_q,
   output reg               pwm_out_q
);

   // Fine position: count with two sub-cycle bits
   wire [DUTY_W-1:0] fine_pos;
   // End of the last sub-cycle of the period
   wire              period_end;
   // Position one step ahead, so high time equals the duty count
   wire [DUTY_W-1:0] fine_next;

   assign fine_pos   = {timer_two_count, timer_two_phase};
   assign fine_next  = fine_pos + {{(DUTY_W-1){1'b0}}, 1'b1};
   assign period_end = (timer_two_count == timer_two_period) && (timer_two_phase == 2'h3);

   // Period restart, duty latch and clear compare
   always @(posedge core_clk)
   begin
      if (reset || !pwm_enable)
      begin
         // Idle low; latch dropped so re-entry starts clean
         pwm_out_q      <= 1'b0;
         duty_latched_q <= {DUTY_W{1'b0}};
      end
      else if (period_end)
      begin
         // Duty of zero never raises the pin
         pwm_out_q      <= (duty_req != {DUTY_W{1'b0}});
         duty_latched_q <= duty_req;
      end
      else if (fine_next == duty_latched_q)
      begin
         // Duty beyond period never matches, pin stays high
         pwm_out_q <= 1'b0;
      end
   end

endmodule

/* File: verilog/cmou_top.v */
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "cmou_consts.vh"

module cmou_top
#(
   parameter SMALL_PACKAGE = 0
)
(
   // Clock and reset
   input  wire        core_clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Timer counts, same clock
   input  wire [15:0] timer_one_count,
   input  wire [15:0] timer_three_count,
   input  wire [7:0]  timer_two_count,
   input  wire [7:0]  timer_two_period,
   input  wire [1:0]  timer_two_phase,
   // Converter status
   input  wire        adc_enabled,
   // Compare pins and ownership
   output reg         unit_one_pin_q,
   output reg         unit_two_pin_q,
   output reg         unit_one_owns_pin_q,
   output reg         unit_two_owns_pin_q,
   // Special event pulses
   output reg         reset_timer_one_q,
   output reg         reset_timer_three_q,
   output reg         adc_start_q,
   // Interrupt
   output reg         irq_q
);

   // True for the compare codes that act on a match
   function is_compare;
      input [3:0] fsel;
      begin
         is_compare = (fsel == `CMOU_FSEL_TOGGLE) || (fsel == `CMOU_FSEL_SET_HIGH) ||
                      (fsel == `CMOU_FSEL_SET_LOW) || (fsel == `CMOU_FSEL_SW_IRQ) ||
                      (fsel == `CMOU_FSEL_SPECIAL);
      end
   endfunction

   // Next compare latch value for a match hit
   function next_latch;
      input [3:0] fsel;
      input       cur;
      input       hit;
      begin
         next_latch = cur;
         if (hit)
         begin
            case (fsel)
               `CMOU_FSEL_SET_HIGH : next_latch = 1'b1;
               `CMOU_FSEL_SET_LOW  : next_latch = 1'b0;
               `CMOU_FSEL_TOGGLE   : next_latch = ~cur;
               default             : next_latch = cur;
            endcase
         end
      end
   endfunction

   // True in pulse-width codes (11xx)
   function is_pwm;
      input [3:0] fsel;
      begin
         is_pwm = (fsel[3:2] == 2'b11);
      end
   endfunction

   // Register state
   reg  [7:0]  one_ctrl_q;       // Unit one control
   reg  [7:0]  one_low_q;        // Unit one value low byte
   reg  [7:0]  one_high_q;       // Unit one value high byte
   reg  [7:0]  two_ctrl_q;       // Unit two control, top bits held zero
   reg  [7:0]  two_low_q;        // Unit two value low byte
   reg  [7:0]  two_high_q;       // Unit two value high byte
   reg  [7:0]  t3_ctrl_q;        // Timer three control copy
   reg  [1:0]  flag_q;           // Match event flags
   reg  [1:0]  mask_q;           // Interrupt enables
   reg  [1:0]  match_prev_q;     // Equality seen last cycle
   reg         one_latch_q;      // Unit one compare output latch
   reg         two_latch_q;      // Unit two compare output latch

   // Combinational next values
   reg  [1:0]  flag_d;
   reg  [1:0]  mask_d;
   reg         one_latch_d;
   reg         two_latch_d;
   reg  [31:0] rdata_d;
   reg         rerr_d;

   // Bus decode
   wire        access;           // Access phase
   wire        commit;           // Edge where master samples pready
   wire        wr;               // Write committing this edge
   wire [7:0]  wbyte;            // Written byte

   // Per-unit derived signals
   wire [3:0]  one_fsel;
   wire [3:0]  two_fsel;
   wire        one_on_t3;        // Unit one uses timer three
   wire        two_on_t3;        // Unit two uses timer three
   wire [15:0] one_base;
   wire [15:0] two_base;
   wire [1:0]  match_now;
   wire [1:0]  hit;              // First cycle of equality, compare code
   wire        one_sev;
   wire        two_sev;
   wire        one_pwm_out;
   wire        two_pwm_out;
   wire [9:0]  one_duty_latched;
   wire [9:0]  two_duty_latched;
   wire        one_zero_wr;      // Zero committed to unit one control
   wire        two_zero_wr;      // Zero committed to unit two control

   assign access = psel && penable;
   assign commit = access && pready;
   assign wr     = commit && pwrite;
   assign wbyte  = pwdata[7:0];

   // Zero writes switch a unit off and clear its latch
   assign one_zero_wr = wr && (paddr == `CMOU_OFS_ONE_CTRL) && (wbyte == `CMOU_RST_BYTE);
   assign two_zero_wr = wr && (paddr == `CMOU_OFS_TWO_CTRL) && (wbyte == `CMOU_RST_BYTE);

   assign one_fsel = one_ctrl_q[`CMOU_FSEL_MSB:`CMOU_FSEL_LSB];
   assign two_fsel = two_ctrl_q[`CMOU_FSEL_MSB:`CMOU_FSEL_LSB];

   assign one_on_t3 = t3_ctrl_q[`CMOU_TBS_HIGH_BIT];
   assign two_on_t3 = t3_ctrl_q[`CMOU_TBS_HIGH_BIT] | t3_ctrl_q[`CMOU_TBS_LOW_BIT];
   assign one_base  = one_on_t3 ? timer_three_count : timer_one_count;
   assign two_base  = two_on_t3 ? timer_three_count : timer_one_count;

   assign match_now[0] = ({one_high_q, one_low_q} == one_base);
   assign match_now[1] = ({two_high_q, two_low_q} == two_base);

   // act only on the first equal cycle
   // only compare codes produce a hit
   assign hit[0] = match_now[0] && !match_prev_q[0] && is_compare(one_fsel);
   assign hit[1] = match_now[1] && !match_prev_q[1] && is_compare(two_fsel);

   assign one_sev = hit[0] && (one_fsel == `CMOU_FSEL_SPECIAL);
   assign two_sev = hit[1] && (two_fsel == `CMOU_FSEL_SPECIAL);

   cmou_pwm #(.DUTY_W(10)) u_pwm_one
   (
      .core_clk         (core_clk),
      .reset            (reset),
      .pwm_enable       (is_pwm(one_fsel)),
      .duty_req         ({one_low_q, one_ctrl_q[`CMOU_DUTY_FRAC_MSB:`CMOU_DUTY_FRAC_LSB]}),
      .timer_two_count  (timer_two_count),
      .timer_two_period (timer_two_period),
      .timer_two_phase  (timer_two_phase),
      .duty_latched_q   (one_duty_latched),
      .pwm_out_q        (one_pwm_out)
   );

   cmou_pwm #(.DUTY_W(10)) u_pwm_two
   (
      .core_clk         (core_clk),
      .reset            (reset),
      .pwm_enable       (is_pwm(two_fsel)),
      .duty_req         ({two_low_q, two_ctrl_q[`CMOU_DUTY_FRAC_MSB:`CMOU_DUTY_FRAC_LSB]}),
      .timer_two_count  (timer_two_count),
      .timer_two_period (timer_two_period),
      .timer_two_phase  (timer_two_phase),
      .duty_latched_q   (two_duty_latched),
      .pwm_out_q        (two_pwm_out)
   );

   // Next flags, mask and compare latches
   always @*
   begin
      // flag set together with pin action; set beats clear
      flag_d = flag_q;
      if (wr && (paddr == `CMOU_OFS_IRQ_STATUS))
      begin
         flag_d = flag_q & ~wbyte[1:0];
      end
      flag_d = flag_d | hit;
      mask_d = mask_q;
      if (wr && (paddr == `CMOU_OFS_IRQ_MASK))
      begin
         mask_d = wbyte[1:0];
      end
      // interrupt-only code leaves the latch alone
      one_latch_d = next_latch(one_fsel, one_latch_q, hit[0]);
      two_latch_d = next_latch(two_fsel, two_latch_q, hit[1]);
      if (one_zero_wr)
      begin
         one_latch_d = 1'b0;
      end
      if (two_zero_wr)
      begin
         two_latch_d = 1'b0;
      end
   end

   // Read data mux
   always @*
   begin
      rdata_d = 32'h0000_0000;
      rerr_d  = 1'b0;
      case (paddr)
         // enhanced config bits hidden on small package
         `CMOU_OFS_ONE_CTRL   : rdata_d[7:0] = (SMALL_PACKAGE != 0) ? {2'h0, one_ctrl_q[5:0]} : one_ctrl_q;
         `CMOU_OFS_ONE_LOW    : rdata_d[7:0] = one_low_q;
         // In pulse-width mode high byte shows the latched duty
         `CMOU_OFS_ONE_HIGH   : rdata_d[7:0] = is_pwm(one_fsel) ? one_duty_latched[9:2] : one_high_q;
         `CMOU_OFS_TWO_CTRL   : rdata_d[7:0] = two_ctrl_q;
         `CMOU_OFS_TWO_LOW    : rdata_d[7:0] = two_low_q;
         `CMOU_OFS_TWO_HIGH   : rdata_d[7:0] = is_pwm(two_fsel) ? two_duty_latched[9:2] : two_high_q;
         `CMOU_OFS_T3_CTRL    : rdata_d[7:0] = t3_ctrl_q;
         `CMOU_OFS_IRQ_STATUS : rdata_d[1:0] = flag_q;
         `CMOU_OFS_IRQ_MASK   : rdata_d[1:0] = mask_q;
         // Unmapped: zero data with error
         default              : rerr_d = 1'b1;
      endcase
   end

   // APB handshake: one wait state, answer from flops
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (access && !pready)
      begin
         // Raise ready with data for the next edge
         pready  <= 1'b1;
         pslverr <= rerr_d;
         prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      end
      else
      begin
         // Drop after the sampling edge
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   // Register writes
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         one_ctrl_q <= `CMOU_RST_BYTE;
         one_low_q  <= `CMOU_RST_BYTE;
         one_high_q <= `CMOU_RST_BYTE;
         two_ctrl_q <= `CMOU_RST_BYTE;
         two_low_q  <= `CMOU_RST_BYTE;
         two_high_q <= `CMOU_RST_BYTE;
         t3_ctrl_q  <= `CMOU_RST_BYTE;
      end
      else if (wr)
      begin
         case (paddr)
            `CMOU_OFS_ONE_CTRL :
            begin
               // Absent bits never stored on the small package
               one_ctrl_q <= (SMALL_PACKAGE != 0) ? {2'h0, wbyte[5:0]} : wbyte;
            end
            `CMOU_OFS_ONE_LOW  : one_low_q <= wbyte;
            // High byte is read-only in pulse-width mode
            `CMOU_OFS_ONE_HIGH :
            begin
               if (!is_pwm(one_fsel))
               begin
                  one_high_q <= wbyte;
               end
            end
            `CMOU_OFS_TWO_CTRL : two_ctrl_q <= wbyte & `CMOU_TWO_CTRL_MASK;
            `CMOU_OFS_TWO_LOW  : two_low_q <= wbyte;
            `CMOU_OFS_TWO_HIGH :
            begin
               if (!is_pwm(two_fsel))
               begin
                  two_high_q <= wbyte;
               end
            end
            `CMOU_OFS_T3_CTRL  : t3_ctrl_q <= wbyte;
            default            : t3_ctrl_q <= t3_ctrl_q;
         endcase
      end
   end

   // Compare state, events and outputs
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         flag_q              <= 2'h0;
         mask_q              <= `CMOU_RST_MASK;
         match_prev_q        <= 2'h0;
         one_latch_q         <= 1'b0;
         two_latch_q         <= 1'b0;
         unit_one_pin_q      <= 1'b0;
         unit_two_pin_q      <= 1'b0;
         unit_one_owns_pin_q <= 1'b0;
         unit_two_owns_pin_q <= 1'b0;
         reset_timer_one_q   <= 1'b0;
         reset_timer_three_q <= 1'b0;
         adc_start_q         <= 1'b0;
         irq_q               <= 1'b0;
      end
      else
      begin
         flag_q       <= flag_d;
         mask_q       <= mask_d;
         match_prev_q <= match_now;
         one_latch_q  <= one_latch_d;
         two_latch_q  <= two_latch_d;
         // Pin follows pulse-width output or compare latch
         // Zero write leaving pulse-width mode drops the pin at once
         unit_one_pin_q <= (is_pwm(one_fsel) && !one_zero_wr) ? one_pwm_out : one_latch_d;
         unit_two_pin_q <= (is_pwm(two_fsel) && !two_zero_wr) ? two_pwm_out : two_latch_d;
         // Pin taken from the port latch only in driving modes
         unit_one_owns_pin_q <= is_pwm(one_fsel) || (is_compare(one_fsel) && (one_fsel != `CMOU_FSEL_SW_IRQ));
         unit_two_owns_pin_q <= is_pwm(two_fsel) || (is_compare(two_fsel) && (two_fsel != `CMOU_FSEL_SW_IRQ));
         // clear the timer each unit is using
         reset_timer_one_q   <= (one_sev && !one_on_t3) || (two_sev && !two_on_t3);
         reset_timer_three_q <= (one_sev && one_on_t3) || (two_sev && two_on_t3);
         // conversion only if converter already on
         adc_start_q <= two_sev && adc_enabled;
         // request reaches processor only when enabled
         irq_q <= |(flag_d & mask_d);
      end
   end

endmodule

/* File: testbench/cmou_checker_assertions.sv */
`timescale 1ns/100ps
`include "cmou_consts.vh"

// Port-level checks on the compare unit
module cmou_checker
(
   // Clock and reset
   input wire        core_clk,
   input wire        reset,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // Pins and triggers
   input wire        adc_enabled,
   input wire        unit_one_pin_q,
   input wire        unit_two_pin_q,
   input wire        unit_one_owns_pin_q,
   input wire        reset_timer_one_q,
   input wire        reset_timer_three_q,
   input wire        adc_start_q
);
   // Completed transfer, the only edge that commits
   wire done = psel & penable & pready;

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   clear_one_a: assert property (
      done && pwrite && paddr == `CMOU_OFS_ONE_CTRL && pwdata[7:0] == 8'h00 |=> !unit_one_pin_q)
      else $error("unit one latch not cleared");
   clear_two_a: assert property (
      done && pwrite && paddr == `CMOU_OFS_TWO_CTRL && pwdata[7:0] == 8'h00 |=> !unit_two_pin_q)
      else $error("unit two latch not cleared");
   two_ctrl_zero_a: assert property (
      done && !pwrite && paddr == `CMOU_OFS_TWO_CTRL |-> prdata[31:6] == 26'h0)
      else $error("unit two top bits not zero");
   upper_zero_a: assert property (
      done && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   err_ready_a: assert property (
      pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
   ready_gap_a: assert property (
      pready |=> !pready)
      else $error("ready held over one cycle");
   trig_one_once_a: assert property (
      reset_timer_one_q |=> !reset_timer_one_q)
      else $error("timer one reset pulse repeated");
   trig_three_once_a: assert property (
      reset_timer_three_q |=> !reset_timer_three_q)
      else $error("timer three reset pulse repeated");
   adc_gate_a: assert property (
      adc_start_q |-> $past(adc_enabled))
      else $error("conversion started while converter off");
   adc_trig_a: assert property (
      adc_start_q |-> reset_timer_one_q || reset_timer_three_q)
      else $error("conversion start without special event");
   pin_rise_owned_a: assert property (
      $rose(unit_one_pin_q) |-> unit_one_owns_pin_q)
      else $error("pin rose in an inert code");
endmodule

bind cmou_top cmou_checker cmou_checker_inst (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .adc_enabled, .unit_one_pin_q, .unit_two_pin_q,
   .unit_one_owns_pin_q, .reset_timer_one_q, .reset_timer_three_q, .adc_start_q);

/* File: testbench/cmou_pin_load.sv */
`timescale 1ns/100ps

// Board load on a compare pin: pull-down when released
module cmou_pin_load
(
   // Unit side
   input  wire pin_q,
   input  wire owns_q,
   // Pad level
   output wire pad
);
   // pad carries latch only when driven
   assign pad = owns_q ? pin_q : 1'b0;
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "cmou_consts.vh"
// One comparison, counted; mismatch reported at once
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end

module tb_top;
   // Bench drive
   logic        core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, adc_enabled = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, seed = 43;
   logic [15:0] t1_cnt = 0, t3_cnt = 0;
   // Design outputs
   wire [31:0]  prdata;
   wire         pready, pslverr, pin1, pin2, own1, own2, rt1, rt3, adc_go, irq;
   wire [1:0]   pad;
   // Counters and model state
   int          num_errors = 0, checks = 0, cyc = 0, pwm_hi = 0;
   // Timer two model: period 3 gives 16 sub-cycles per period
   logic [7:0]  t2_cnt = 0, t2_per = 8'h03;
   logic [1:0]  t2_ph = 0;
   logic [1:0]  m_pin = 0, m_st = 0, m_msk = 0;
   logic [3:0]  codes[$] = '{4'h8, 4'h2, 4'h2, 4'h9, 4'hA, 4'hB, 4'h0, 4'h4, 4'h8, 4'h2};

   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;

   // Timer two free-running: sub-cycle phase, count wraps at period
   always @(posedge core_clk)
   begin
      t2_ph <= t2_ph + 2'h1;
      if (t2_ph == 2'h3) t2_cnt <= (t2_cnt == t2_per) ? 8'h00 : t2_cnt + 8'h01;
   end

   cmou_top cmou_top_inst (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .timer_one_count(t1_cnt), .timer_three_count(t3_cnt), .timer_two_count(t2_cnt),
      .timer_two_period(t2_per), .timer_two_phase(t2_ph), .adc_enabled, .unit_one_pin_q(pin1),
      .unit_two_pin_q(pin2), .unit_one_owns_pin_q(own1), .unit_two_owns_pin_q(own2),
      .reset_timer_one_q(rt1), .reset_timer_three_q(rt3), .adc_start_q(adc_go), .irq_q(irq));
   cmou_pin_load cmou_pin_load_inst[1:0] (.pin_q({pin2, pin1}), .owns_q({own2, own1}), .pad(pad));

   // Fixed-seed xorshift
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Verdict and end of run
   task results;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // APB transfer; waits for ready, bounded
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
            output logic er);
      int n;
      @(posedge core_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      n = 0;
      do @(posedge core_clk); while (pready !== 1'b1 && ++n < 20);
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // Write, upper bits filled to show they are ignored
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        er;
      apb(1, a, {24'hFFFFFF, d}, r, er);
   endtask

   // Read and compare data and error
   task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] r;
      logic        er;
      apb(0, a, 0, r, er);
      `CHK("prdata", e, r)
      `CHK("pslverr", ee, er)
   endtask

   // One match on unit u with code c, then hold equality
   task hit(input logic [3:0] c, input int u);
      logic [31:0] v;
      logic [7:0]  b;
      v = xs();
      b = u ? `CMOU_OFS_TWO_CTRL : `CMOU_OFS_ONE_CTRL;
      // timer counts parked at the complement, so no equality fires during setup
      t1_cnt <= ~v[15:0];
      t3_cnt <= ~v[15:0];
      adc_enabled <= v[20];
      m_msk = v[22:21];
      wr(`CMOU_OFS_IRQ_MASK, {6'h0, m_msk});
      wr(b + 8'h04, v[7:0]);
      rdc(b + 8'h04, v[7:0], 0);
      wr(b + 8'h08, v[15:8]);
      wr(b, {4'h0, c});
      if (c == 4'h0) m_pin[u] = 0;
      if (u) t3_cnt <= v[15:0];
      else t1_cnt <= v[15:0];
      @(posedge core_clk);
      #1;
      // Expected pin action per code
      if (c == 4'h8) m_pin[u] = 1;
      if (c == 4'h9) m_pin[u] = 0;
      if (c == 4'h2) m_pin[u] = ~m_pin[u];
      if (c inside {4'h2, 4'h8, 4'h9, 4'hA, 4'hB}) m_st[u] = 1;
      `CHK("pin", m_pin[u], u ? pin2 : pin1)
      `CHK("pad", (c inside {4'h2, 4'h8, 4'h9, 4'hB}) & m_pin[u], pad[u])
      `CHK("irq", |(m_st & m_msk), irq)
      `CHK("trig", c == 4'hB, u ? rt3 : rt1)
      `CHK("adc", c == 4'hB && u && adc_enabled, adc_go)
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("pin hold", m_pin[u], u ? pin2 : pin1)
      rdc(`CMOU_OFS_IRQ_STATUS, m_st, 0);
      wr(`CMOU_OFS_IRQ_STATUS, 8'h03);
      m_st = 0;
      @(posedge core_clk);
      #1;
      `CHK("irq clear", 1'b0, irq)
   endtask

   // Hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         results();
      end
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge core_clk);
      reset <= 0;
      for (int a = 0; a <= 32; a += 4) rdc(8'(a), 0, 0);
      rdc(8'h24, 0, 1);
      wr(`CMOU_OFS_TWO_CTRL, 8'hFF);
      rdc(`CMOU_OFS_TWO_CTRL, 8'h3F, 0);
      wr(`CMOU_OFS_TWO_CTRL, 8'h00);
      wr(`CMOU_OFS_ONE_CTRL, 8'hC0);
      rdc(`CMOU_OFS_ONE_CTRL, 8'hC0, 0);
      wr(`CMOU_OFS_ONE_CTRL, 8'h00); // switch off before a new mode
      // Unit two on timer three, unit one on timer one
      wr(`CMOU_OFS_T3_CTRL, 8'h08);
      rdc(`CMOU_OFS_T3_CTRL, 8'h08, 0);
      for (int i = 0; i < 20; i++) hit(codes[i % 10], i / 10);
      // Pulse-width: duty {01, 2'b10} = 6 of 16 sub-cycles
      wr(`CMOU_OFS_ONE_LOW, 8'h01);
      wr(`CMOU_OFS_ONE_CTRL, 8'h2C);
      repeat (40) @(posedge core_clk);
      rdc(`CMOU_OFS_ONE_HIGH, 8'h01, 0);
      repeat (32)
      begin
         @(posedge core_clk);
         #1;
         pwm_hi += pin1;
      end
      `CHK("pwm high", 12, pwm_hi)
      `CHK("pwm pad", pin1, pad[0])
      wr(`CMOU_OFS_ONE_CTRL, 8'h00);
      @(posedge core_clk);
      #1;
      `CHK("pwm off pin", 1'b0, pin1)
      results();
   end
endmodule
